//--- rtl/ric_pkg.sv
// reset and interrupt control: shared constants and carrier types
// assumes one 200 MHz core clock and a CPU core on the far side
`default_nettype none
package ric_pkg;
  localparam logic [15:0] VEC_RESET = 16'h1FFE;
  localparam logic [15:0] VEC_TRAP  = 16'h1FFC;
  localparam logic [15:0] VEC_PIN   = 16'h1FFA;
  localparam logic [15:0] VEC_CORE  = 16'h1FF8;
  localparam logic [15:0] VEC_LOWV  = 16'h1FF6;
  localparam logic [15:0] VEC_T16   = 16'h1FF4;
  localparam logic [15:0] VEC_KEYS  = 16'h1FF2;
  localparam logic [15:0] WDOG_ADDR = 16'h1FF0;
  localparam logic [15:0] RAM_LO    = 16'h0080;
  localparam logic [15:0] RAM_HI    = 16'h00FF;
  localparam logic [15:0] EE_LO     = 16'h0100;
  localparam logic [15:0] EE_HI     = 16'h019F;
  localparam logic [15:0] ROM_LO    = 16'h0800;
  localparam logic [15:0] EPROM_LO  = 16'h0700;
  localparam logic [15:0] ROM_HI    = 16'h1FFF;
  // apb register byte addresses
  localparam logic [11:0] A_OPT     = 12'h000;
  localparam logic [11:0] A_CTCS    = 12'h004;
  localparam logic [11:0] A_STAT    = 12'h008;
  // options register bits
  localparam int OPT_WDOG_EN = 0;
  localparam int OPT_PIN_LVL = 1;
  localparam int OPT_LV_EN   = 2;
  localparam int OPT_LV_CLR  = 3;
  localparam int OPT_LV_FLAG = 4;
  // core timer control/status bits
  localparam int CT_OVF_FLAG = 7;
  localparam int CT_RT_FLAG  = 6;
  localparam int CT_OVF_EN   = 5;
  localparam int CT_RT_EN    = 4;
  localparam int CT_RT_CLR   = 3;
  localparam int CT_OVF_CLR  = 2;
  localparam int CT_RATE_LO  = 0;
  // timing
  localparam real CLK_MHZ     = 200.0;
  localparam real MCYC_NS     = 500.0;  // machine cycle at 2 MHz bus
  localparam int  MCYC_CYC    = int'(MCYC_NS * CLK_MHZ / 1000.0);
  localparam int  PIN_MIN_CYC = (3 * MCYC_CYC + 1) / 2;  // 1.5 cycles
  localparam int  POR_CYC     = 8192;   // power_up_hold_delay in cycles
  localparam int  WDOG_CYC    = 65536;
  localparam int  TICK_DIV    = 4;      // core timer prescale
  typedef enum logic [2:0] {
    SRC_NONE = 3'b000, SRC_TRAP = 3'b001, SRC_PIN = 3'b010,
    SRC_CORE = 3'b011, SRC_LOWV = 3'b100, SRC_T16 = 3'b101,
    SRC_KEYS = 3'b110
  } ric_src_t;
  typedef struct packed {
    logic        boundary;     // instruction complete
    logic        fetch;        // opcode fetch strobe
    logic [15:0] fetch_addr;
    logic        trap_fetch;   // software_trap fetched
    logic        mask;         // condition_code_reg mask now
    logic        ret;          // return_from_service executing
    logic        stacked_mask; // mask value popped
    logic        svc_start;    // service routine entered
  } ric_cpu_t;
  typedef struct packed {
    logic        take;
    logic [15:0] vector;
    logic        set_mask;
    logic        clr_mask;
    logic        push;
  } ric_vec_t;
endpackage
`default_nettype wire

//--- rtl/ric_top.sv
// reset and interrupt control top: reset causes, watchdog, priority
// assumes cpu status as synchronous strobes, apb from system bus
`default_nettype none
module ric_top
  import ric_pkg::*;
#(
  parameter int  POR_CYCLES  = ric_pkg::POR_CYC,
  parameter int  WDOG_CYCLES = ric_pkg::WDOG_CYC,
  parameter bit  PROG_PART   = 1'b1,
  parameter bit  WDOG_STRAP  = 1'b0
) (
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  input  wire logic              reset_pin_n,
  input  wire logic              osc_ready,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic      [31:0]       prdata,
  output logic                   pslverr,
  input  wire ric_pkg::ric_cpu_t cpu,
  input  wire logic              wr_strobe,
  input  wire logic [15:0]       wr_addr,
  input  wire logic [7:0]        wr_data,
  input  wire logic              irq_pin_n,
  input  wire logic              lv_pin_n,
  input  wire logic              t16_req,
  input  wire logic              keys_req,
  output ric_pkg::ric_vec_t      vec,
  output logic                   cpu_reset,
  output logic                   keep_mode
);
  import ric_pkg::*;

  if (POR_CYCLES < 1 || WDOG_CYCLES < 2) begin : gen_bad_counts
    $error("bad counts");
  end

  //////////////////////////////////////////////////////////////////////////
  // reset synchroniser and causes
  logic        rs1_ff, rs2_ff;
  logic [31:0] por_cnt_ff;
  logic        por_done_ff;
  logic [15:0] pin_cnt_ff;
  logic        pin_rst_ff;
  logic [31:0] wd_cnt_ff;
  logic        int_rst_ff;
  logic [7:0]  opt_ff;
  logic [7:0]  ct_ff;
  logic        wd_strap_ff;
  logic        boot_hold_ff;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rs1_ff <= 1'b0;
      rs2_ff <= 1'b0;
    end else begin
      rs1_ff <= 1'b1;
      rs2_ff <= rs1_ff;
    end
  end
  wire rst_n = rs2_ff;

  wire por_tick = osc_ready && !por_done_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      por_cnt_ff  <= '0;
      por_done_ff <= 1'b0;
      wd_strap_ff <= 1'b0;
      boot_hold_ff <= 1'b1;
    end else begin
      wd_strap_ff <= WDOG_STRAP;
      // hold until pin high after delay
      if (por_done_ff && reset_pin_n) boot_hold_ff <= 1'b0;
      if (por_tick) por_cnt_ff <= por_cnt_ff + 32'd1;
      if (por_tick && por_cnt_ff == 32'(POR_CYCLES - 1))
        por_done_ff <= 1'b1;
    end
  end

  wire pin_long = pin_cnt_ff >= 16'(PIN_MIN_CYC - 1);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_cnt_ff <= '0;
      pin_rst_ff <= 1'b0;
    end else begin
      pin_cnt_ff <= reset_pin_n ? 16'h0000
                  : (pin_long ? pin_cnt_ff : pin_cnt_ff + 16'h0001);
      pin_rst_ff <= !reset_pin_n && pin_long;
    end
  end

  // boot or pin reset clears enables
  wire ext_rst = boot_hold_ff || pin_rst_ff;

  wire wd_en = PROG_PART ? opt_ff[OPT_WDOG_EN] : wd_strap_ff;
  wire wd_kick = wr_strobe && wr_addr == WDOG_ADDR && !wr_data[0];
  wire [15:0] prog_lo = PROG_PART ? EPROM_LO : ROM_LO;
  wire in_ram  = cpu.fetch_addr >= RAM_LO && cpu.fetch_addr <= RAM_HI;
  wire in_ee   = cpu.fetch_addr >= EE_LO && cpu.fetch_addr <= EE_HI;
  wire in_rom  = cpu.fetch_addr >= prog_lo && cpu.fetch_addr <= ROM_HI;
  wire illegal = cpu.fetch && !(in_ram || in_ee || in_rom);
  wire wd_out  = wd_en && wd_cnt_ff == 32'(WDOG_CYCLES - 1);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_cnt_ff  <= '0;
      int_rst_ff <= 1'b0;
      keep_mode  <= 1'b0;
    end else begin
      wd_cnt_ff  <= (wd_kick || !wd_en || wd_out) ? 32'd0
                  : wd_cnt_ff + 32'd1;
      int_rst_ff <= wd_out || illegal;
      if (wd_out) keep_mode <= 1'b1;
      else if (ext_rst) keep_mode <= 1'b0;
    end
  end

  wire any_rst  = ext_rst || int_rst_ff;
  assign cpu_reset = any_rst;

  //////////////////////////////////////////////////////////////////////////
  // core timer, pin latch, low voltage
  logic [1:0]  div_ff;
  logic [7:0]  ctr_ff;
  logic        pin_d_ff, pin_lat_ff, lv_d_ff;
  logic        tick;
  logic        trap_pend_ff, trap_early_ff;
  ric_src_t    cur_ff;
  assign tick = div_ff == 2'(TICK_DIV - 1);
  wire [7:0] rt_mask = 8'h0F << ct_ff[1:0];
  wire apb_wr  = psel && penable && pwrite;
  wire wr_opt  = apb_wr && paddr == A_OPT;
  wire wr_ct   = apb_wr && paddr == A_CTCS;
  wire ovf_set = tick && ctr_ff == 8'hFF;
  wire rt_set  = tick && (ctr_ff & rt_mask) == rt_mask;
  wire pin_fall = pin_d_ff && !irq_pin_n;
  wire lv_edge  = lv_d_ff != lv_pin_n;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= '0;
      ctr_ff <= '0;
    end else begin
      div_ff <= tick ? 2'b00 : div_ff + 2'b01;
      if (tick) ctr_ff <= ctr_ff + 8'h01;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      opt_ff <= '0;
      ct_ff  <= '0;
    end else if (ext_rst) begin
      opt_ff <= '0;
      ct_ff  <= '0;
    end else begin
      if (wr_opt) begin
        opt_ff[OPT_LV_EN:OPT_WDOG_EN] <= pwdata[OPT_LV_EN:OPT_WDOG_EN];
      end
      if (opt_ff[OPT_LV_EN] && lv_edge) opt_ff[OPT_LV_FLAG] <= 1'b1;
      else if (wr_opt && pwdata[OPT_LV_CLR]) opt_ff[OPT_LV_FLAG] <= 1'b0;
      if (wr_ct) begin
        ct_ff[CT_OVF_EN:CT_RT_EN] <= pwdata[CT_OVF_EN:CT_RT_EN];
        ct_ff[CT_RATE_LO+1:CT_RATE_LO] <= pwdata[CT_RATE_LO+1:CT_RATE_LO];
      end
      // timer flags, set wins over clear
      if (ovf_set && ct_ff[CT_OVF_EN]) ct_ff[CT_OVF_FLAG] <= 1'b1;
      else if (wr_ct && pwdata[CT_OVF_CLR]) ct_ff[CT_OVF_FLAG] <= 1'b0;
      if (rt_set && ct_ff[CT_RT_EN]) ct_ff[CT_RT_FLAG] <= 1'b1;
      else if (wr_ct && pwdata[CT_RT_CLR]) ct_ff[CT_RT_FLAG] <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_d_ff   <= 1'b1;
      lv_d_ff    <= 1'b1;
      pin_lat_ff <= 1'b0;
    end else begin
      pin_d_ff <= irq_pin_n;
      lv_d_ff  <= lv_pin_n;
      if (pin_fall) pin_lat_ff <= 1'b1;
      else if (cpu.svc_start && cur_ff == SRC_PIN) pin_lat_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // priority and vector
  wire pin_req  = pin_lat_ff || (opt_ff[OPT_PIN_LVL] && !irq_pin_n);
  wire core_req = ct_ff[CT_OVF_FLAG] || ct_ff[CT_RT_FLAG];
  wire lv_req   = opt_ff[OPT_LV_FLAG];
  wire open_m   = !cpu.mask;
  wire mask_req = pin_req || core_req || lv_req || t16_req || keys_req;
  wire trap_go  = trap_pend_ff && !(trap_early_ff && open_m && mask_req);
  ric_src_t win;
  assign win = trap_go                 ? SRC_TRAP :
               (open_m && pin_req)     ? SRC_PIN  :
               (open_m && core_req)    ? SRC_CORE :
               (open_m && lv_req)      ? SRC_LOWV :
               (open_m && t16_req)     ? SRC_T16  :
               (open_m && keys_req)    ? SRC_KEYS : SRC_NONE;
  logic [15:0] win_vec;
  always_comb begin
    case (win)
      SRC_TRAP: win_vec = VEC_TRAP;
      SRC_PIN:  win_vec = VEC_PIN;
      SRC_CORE: win_vec = VEC_CORE;
      SRC_LOWV: win_vec = VEC_LOWV;
      SRC_T16:  win_vec = VEC_T16;
      SRC_KEYS: win_vec = VEC_KEYS;
      default:  win_vec = VEC_RESET;
    endcase
  end

  wire take = cpu.boundary && win != SRC_NONE && !any_rst;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trap_pend_ff <= 1'b0;
      trap_early_ff <= 1'b0;
      cur_ff       <= SRC_NONE;
      vec          <= '0;
    end else begin
      // note requests pending at trap fetch
      if (cpu.trap_fetch) trap_early_ff <= open_m && mask_req;
      if (cpu.trap_fetch) trap_pend_ff <= 1'b1;
      else if (take && win == SRC_TRAP) trap_pend_ff <= 1'b0;
      if (take) cur_ff <= win;
      vec.take <= take || any_rst;
      vec.vector <= any_rst ? VEC_RESET : win_vec;
      vec.push     <= take;
      vec.set_mask <= take || any_rst;
      vec.clr_mask <= cpu.ret && !cpu.stacked_mask && !any_rst;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait
  wire mapped = paddr == A_OPT || paddr == A_CTCS || paddr == A_STAT;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  always_comb begin
    case (paddr)
      A_OPT:   prdata = {24'h000000, opt_ff & 8'hF7};
      A_CTCS:  prdata = {24'h000000, ct_ff & 8'hF3};
      A_STAT:  prdata = {23'h000000, keep_mode, lv_pin_n, trap_pend_ff,
                         pin_lat_ff, wd_en, 1'b0, cur_ff};
      default: prdata = 32'h00000000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  // take waits for boundary
  take_bound_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    vec.push |-> $past(cpu.boundary)) else $error("take off boundary");
  rst_vec_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(any_rst) && $past(rst_n) |-> vec.vector == VEC_RESET
    && vec.set_mask)
    else $error("reset vector wrong");
  push_mask_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    vec.push |-> vec.set_mask) else $error("no mask on push");
  mask_block_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cpu.mask && !trap_go |-> win == SRC_NONE) else $error("mask leak");
  ovf_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ovf_set && ct_ff[CT_OVF_EN] && !ext_rst |=> ct_ff[CT_OVF_FLAG])
    else $error("overflow flag missed");
  bad_fetch_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    illegal |=> cpu_reset) else $error("illegal fetch no reset");
  en_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ext_rst |=> ct_ff[CT_OVF_EN] == 1'b0 && opt_ff[OPT_LV_EN] == 1'b0)
    else $error("enable survived reset");
  wd_kick_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    wd_kick |=> wd_cnt_ff == 32'd0) else $error("kick ignored");
  por_hold_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !por_done_ff || (boot_hold_ff && !reset_pin_n) |-> cpu_reset)
    else $error("power-up reset dropped");
  pin_resume_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    reset_pin_n |=> !pin_rst_ff)
    else $error("pin reset held too long");
  wd_fire_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wd_out |=> cpu_reset && keep_mode)
    else $error("watchdog reset missing");
  wd_off_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !wd_en |=> wd_cnt_ff == 32'd0)
    else $error("watchdog ran while off");
  clr_mask_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    cpu.ret && !cpu.stacked_mask && !any_rst |=> vec.clr_mask)
    else $error("mask not cleared on return");
  sequence trap_ready_s;
    cpu.boundary && trap_go && !any_rst;
  endsequence
  sequence trap_out_s;
    vec.take && vec.push && vec.vector == VEC_TRAP;
  endsequence
  trap_first_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    trap_ready_s |=> trap_out_s)
    else $error("trap not taken");
  pin_latch_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    pin_fall |=> pin_lat_ff)
    else $error("pin edge lost");
  rt_flag_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    rt_set && ct_ff[CT_RT_EN] && !ext_rst |=> ct_ff[CT_RT_FLAG])
    else $error("realtime flag missed");
  lv_clear_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wr_opt && pwdata[OPT_LV_CLR] && !ext_rst
    && !(opt_ff[OPT_LV_EN] && lv_edge) |=> !opt_ff[OPT_LV_FLAG])
    else $error("low-voltage flag not cleared");
endmodule
`default_nettype wire

//--- tb/ric_cpu_model.sv
// cpu core stand-in: turns bench commands into one-cycle status strobes
// assumes commands change right after a rising edge and last one cycle
`default_nettype none
module ric_cpu_model (
  input  wire logic              core_clk,
  input  wire logic              cpu_reset,
  input  wire ric_pkg::ric_vec_t vec,
  input  wire logic [2:0]        cmd,
  input  wire logic [15:0]       cmd_addr,
  output var  ric_pkg::ric_cpu_t cpu
);
  import ric_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic trap_pend;
  always @(posedge core_clk) begin
    cpu.trap_fetch <= (cmd == 3'd2);
    trap_pend      <= (cmd == 3'd2);
    cpu.boundary   <= (cmd == 3'd1) || trap_pend;
    cpu.ret          <= (cmd == 3'd3);
    cpu.stacked_mask <= 1'b0;
    cpu.fetch      <= (cmd == 3'd4);
    cpu.fetch_addr <= (cmd == 3'd4) ? cmd_addr : ROM_LO;
    cpu.svc_start <= vec.take;
    if (cpu_reset || vec.set_mask) begin
      cpu.mask <= 1'b1;
    end else if (vec.clr_mask || cmd == 3'd5) begin
      cpu.mask <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// testbench top: reset causes, priority, core timer, options, watchdog
// assumes the cpu model file and the design package compiled before it
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ric_pkg::*;
  logic core_clk = 0, reset_n = 0, reset_pin_n = 0, osc_ready = 1;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic wr_strobe = 0, irq_pin_n = 1, lv_pin_n = 1, t16_req = 0;
  logic keys_req = 0, cpu_reset, keep_mode, prev_rst = 0;
  logic [15:0] wr_addr = '0, cmd_addr = '0;
  logic [7:0] wr_data = '0;
  logic [2:0] cmd = '0;
  logic [16:0] rnd = 17'h182FC;
  ric_cpu_t cpu;
  ric_vec_t vec;
  int miscompares = 0, checked = 0, cyc = 0, resets = 0, n;
  logic [32:0] rq[$];
  logic [15:0] vq[$];
  logic [15:0] fa[6] = '{16'h007F, 16'h0080, 16'h019F, 16'h01A0,
                         16'h06FF, 16'h0700};
  logic [5:0] bad = 6'b011001;
  ric_top #(.POR_CYCLES(16), .WDOG_CYCLES(64)) ric_top_inst (
    .core_clk(core_clk), .reset_n(reset_n), .reset_pin_n(reset_pin_n),
    .osc_ready(osc_ready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .cpu(cpu),
    .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data),
    .irq_pin_n(irq_pin_n), .lv_pin_n(lv_pin_n), .t16_req(t16_req),
    .keys_req(keys_req), .vec(vec), .cpu_reset(cpu_reset),
    .keep_mode(keep_mode));
  ric_cpu_model ric_cpu_model_inst (.core_clk(core_clk),
    .cpu_reset(cpu_reset), .vec(vec), .cmd(cmd), .cmd_addr(cmd_addr),
    .cpu(cpu));
  always #2.5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [16:0] lfsr(input logic [16:0] x);
    return {x[15:0], x[16] ^ x[13]};
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  task automatic check(input string what, input logic [32:0] exp,
                       input logic [32:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 0; penable <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] exp);
    rq.push_back(exp);
    apb(0, a, '0);
  endtask
  task automatic op(input logic [2:0] c, input logic [15:0] a);
    @(posedge core_clk);
    cmd <= c; cmd_addr <= a;
    @(posedge core_clk);
    cmd <= 3'd0;
    tick(4);
  endtask
  task automatic results();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      results();
    end
  end
  always @(posedge core_clk) begin
    if (cpu_reset === 1'b1 && prev_rst === 1'b0) resets++;
    prev_rst <= cpu_reset;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (rq.size() == 0) check("read", 0, 1);
      else check("read", rq.pop_front(), {pslverr, prdata});
    end
    if (vec.take === 1'b1 && prev_rst === 1'b1) begin
      check("reset vector", VEC_RESET, vec.vector);
      check("reset mask", 2'b01, {vec.push, vec.set_mask});
    end else if (vec.take === 1'b1) begin
      if (vq.size() == 0) check("unexpected take", 0, 1);
      else check("vector", vq.pop_front(), vec.vector);
      check("push and mask", 2'b11, {vec.push, vec.set_mask});
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    tick(2);
    reset_n <= 1;
    tick(40);
    check("reset pin hold", 1, cpu_reset);
    reset_pin_n <= 1;
    tick(4);
    check("reset released", 0, cpu_reset);
    rd(A_OPT, 0);
    rd(A_CTCS, 0);
    rd(12'h00C, 33'h100000000);
    t16_req <= 1; keys_req <= 1;
    op(3'd1, 0);
    op(3'd5, 0);
    vq.push_back(VEC_T16);
    op(3'd1, 0);
    t16_req <= 0; keys_req <= 0;
    op(3'd3, 0);
    vq.push_back(VEC_TRAP);
    op(3'd2, 0);
    irq_pin_n <= 0;
    op(3'd3, 0);
    vq.push_back(VEC_PIN);
    op(3'd1, 0);
    irq_pin_n <= 1; keys_req <= 1;
    op(3'd3, 0);
    vq.push_back(VEC_KEYS);
    op(3'd1, 0);
    keys_req <= 0;
    op(3'd3, 0);
    apb(1, A_CTCS, 32'h1 << CT_OVF_EN);
    vq.push_back(VEC_CORE);
    for (int i = 0; i < 400 && vq.size() != 0; i++) op(3'd1, 0);
    apb(1, A_CTCS, 32'h1 << CT_OVF_CLR);
    apb(1, A_CTCS, 32'h1 << CT_RT_EN);
    tick(80);
    rd(A_CTCS, 32'h50);
    apb(1, A_CTCS, 32'h1 << CT_RT_CLR);
    apb(1, A_OPT, 32'h1 << OPT_LV_EN);
    lv_pin_n <= 0;
    tick(6);
    rd(A_OPT, 32'h14);
    apb(1, A_OPT, 32'h0C);
    rd(A_OPT, 32'h04);
    apb(1, A_OPT, 32'h1 << OPT_WDOG_EN);
    lv_pin_n <= 1;
    n = resets;
    repeat (4) begin
      rnd = lfsr(rnd);
      wr_strobe <= 1; wr_addr <= WDOG_ADDR; wr_data <= rnd[7:0] & 8'hFE;
      tick(1);
      wr_strobe <= 0;
      tick(40);
    end
    check("serviced watchdog", n, resets);
    for (int i = 0; i < 200 && resets == n; i++) tick(1);
    check("watchdog reset", n + 1, resets);
    check("mode kept", 1, keep_mode);
    reset_pin_n <= 0;
    tick(PIN_MIN_CYC + 2);
    check("pin reset", 1, cpu_reset);
    reset_pin_n <= 1;
    tick(4);
    check("pin resume", 0, cpu_reset);
    rd(A_OPT, 0);
    apb(1, A_OPT, 32'h1 << OPT_PIN_LVL);
    irq_pin_n <= 0;
    op(3'd5, 0);
    vq.push_back(VEC_PIN);
    op(3'd1, 0);
    op(3'd3, 0);
    vq.push_back(VEC_PIN);
    op(3'd1, 0);
    irq_pin_n <= 1;
    op(3'd3, 0);
    foreach (fa[i]) begin
      n = resets;
      op(3'd4, fa[i]);
      check("fetch reset", n + bad[i], resets);
      for (int j = 0; j < 300 && cpu_reset !== 1'b0; j++) tick(1);
    end
    check("vectors left", 0, vq.size());
    check("reads left", 0, rq.size());
    results();
  end
endmodule
`default_nettype wire
